// *** hdl/lo_bias_pkg.sv ***
`default_nettype none

package lo_bias_pkg;

  // register offsets
  localparam logic [7:0] OSC_BUFFER_BIAS_ADDR = 8'h19;
  localparam logic [7:0] LOOP_BANDWIDTH_ADDR = 8'h1A;
  localparam logic [7:0] CAL_CONTROL_ADDR = 8'h1B;
  localparam logic [7:0] CAL_STATUS_ADDR = 8'h40;
  localparam logic [7:0] RESULT_A_ADDR = 8'h41;
  localparam logic [7:0] RESULT_B_ADDR = 8'h42;

  // field layout of oscillator_buffer_bias, msb first
  typedef struct packed {
    logic [1:0] pre;
    logic [2:0] rx;
    logic [2:0] tx;
  } bias_reg_t;

  // field layout of calibration_control, msb first
  typedef struct packed {
    logic start;
    logic dual;
    logic [1:0] wait_code;
    logic reserved;
    logic [2:0] step;
  } cal_reg_t;

  // reset values
  localparam logic [1:0] PRE_RST = 2'h1;
  localparam logic [2:0] RX_RST = 3'h4;
  localparam logic [2:0] TX_RST = 3'h5;
  localparam logic [7:0] LOOP_BANDWIDTH_RST = 8'h86;
  localparam logic [1:0] WAIT_RST = 2'h0;
  localparam logic [2:0] STEP_RST = 3'h5;
  localparam bias_reg_t BIAS_RST = '{pre: PRE_RST, rx: RX_RST, tx: TX_RST};
  localparam cal_reg_t CAL_RST = '{start: 1'b0, dual: 1'b0,
    wait_code: WAIT_RST, reserved: 1'b0, step: STEP_RST};

  // calibration times in reference-clock periods
  localparam int WAIT0_PERIODS = 90000;
  localparam int WAIT1_PERIODS = 110000;
  localparam int WAIT2_PERIODS = 130000;
  localparam int WAIT3_PERIODS = 200000;

  // calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } cal_state_t;

endpackage

`default_nettype wire

// *** hdl/lo_bias_and_pll_calibration_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module lo_bias_and_pll_calibration_regs
  import lo_bias_pkg::*;
#(
  parameter int WAIT0 = WAIT0_PERIODS,
  parameter int WAIT1 = WAIT1_PERIODS,
  parameter int WAIT2 = WAIT2_PERIODS,
  parameter int WAIT3 = WAIT3_PERIODS,
  parameter int CNT_W = 18
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // calibration environment
  input wire logic REF_TICK,
  input wire logic FREQ_SELECT,
  input wire logic [7:0] CAL_MEASURE,
  // bias settings
  output logic [3:0] PRE_BIAS_NUM,
  output logic [3:0] PRE_BIAS_DEN,
  output logic [2:0] RX_BUFFER_BIAS,
  output logic [2:0] TX_BUFFER_BIAS,
  output logic [7:0] LOOP_BANDWIDTH,
  // calibration outputs
  output logic CAL_ACTIVE,
  output logic [3:0] DAC_INITIAL_STEP,
  output logic [7:0] RESULT_A,
  output logic [7:0] RESULT_B
);

  // refuse parameters the counter cannot serve
  if (CNT_W < 2 || CNT_W > 30) begin : g_bad_width
    $error("counter width out of range");
  end
  if (WAIT0 < 1 || WAIT1 < 1 || WAIT2 < 1 || WAIT3 < 1) begin : g_bad_wait
    $error("calibration wait must be at least one period");
  end
  if (WAIT0 >= (1 << CNT_W) || WAIT1 >= (1 << CNT_W) ||
      WAIT2 >= (1 << CNT_W) || WAIT3 >= (1 << CNT_W)) begin : g_bad_fit
    $error("calibration wait does not fit the counter");
  end

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  bias_reg_t bias, next_bias;
  cal_reg_t cal, next_cal;
  logic [7:0] loop_bw, next_loop_bw;
  logic [7:0] next_rdata;
  logic [3:0] next_num, next_den;
  cal_state_t state, next_state;
  logic [CNT_W-1:0] count, next_count;
  logic [3:0] next_dac;
  logic [7:0] next_result_a, next_result_b;
  logic wr_bias, wr_loop, wr_cal;
  logic cal_end, start_edge, abort;
  cal_reg_t wcal;
  logic [CNT_W-1:0] start_periods;

  assign wcal = cal_reg_t'(WDATA);
  assign wr_bias = WR && (ADDR == OSC_BUFFER_BIAS_ADDR);
  assign wr_loop = WR && (ADDR == LOOP_BANDWIDTH_ADDR);
  assign wr_cal = WR && (ADDR == CAL_CONTROL_ADDR);
  assign cal_end = (state == CAL_RUN) && REF_TICK && (count == CNT_ONE);
  assign start_edge = wr_cal && wcal.start && (!cal.start || cal_end);
  assign abort = wr_cal && !wcal.start && (state == CAL_RUN);

  always_comb begin
    case (wcal.wait_code)
      2'h0: start_periods = CNT_W'(WAIT0);
      2'h1: start_periods = CNT_W'(WAIT1);
      2'h2: start_periods = CNT_W'(WAIT2);
      default: start_periods = CNT_W'(WAIT3);
    endcase
  end

  // register file next values
  always_comb begin
    next_bias = bias;
    next_loop_bw = loop_bw;
    next_cal = cal;
    next_rdata = 8'h00;
    if (cal_end) begin
      next_cal.start = 1'b0;
    end
    if (wr_bias) begin
      next_bias = bias_reg_t'(WDATA);
    end
    if (wr_loop) begin
      next_loop_bw = WDATA;
    end
    if (wr_cal) begin
      next_cal = wcal;
      next_cal.reserved = 1'b0;
    end
    if (RD) begin
      case (ADDR)
        OSC_BUFFER_BIAS_ADDR: next_rdata = bias;
        LOOP_BANDWIDTH_ADDR: next_rdata = loop_bw;
        CAL_CONTROL_ADDR: next_rdata = cal;
        CAL_STATUS_ADDR: next_rdata = {7'h00, state == CAL_RUN};
        RESULT_A_ADDR: next_rdata = RESULT_A;
        RESULT_B_ADDR: next_rdata = RESULT_B;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    case (next_bias.pre)
      2'h0: begin
        next_num = 4'h1;
        next_den = 4'h1;
      end
      2'h1: begin
        next_num = 4'h2;
        next_den = 4'h3;
      end
      2'h2: begin
        next_num = 4'h1;
        next_den = 4'h2;
      end
      default: begin
        next_num = 4'h2;
        next_den = 4'h5;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      bias <= BIAS_RST;
      loop_bw <= LOOP_BANDWIDTH_RST;
      cal <= CAL_RST;
      RDATA <= 8'h00;
      PRE_BIAS_NUM <= 4'h2;
      PRE_BIAS_DEN <= 4'h3;
      RX_BUFFER_BIAS <= RX_RST;
      TX_BUFFER_BIAS <= TX_RST;
      LOOP_BANDWIDTH <= LOOP_BANDWIDTH_RST;
    end else if (CE) begin
      bias <= next_bias;
      loop_bw <= next_loop_bw;
      cal <= next_cal;
      RDATA <= next_rdata;
      PRE_BIAS_NUM <= next_num;
      PRE_BIAS_DEN <= next_den;
      RX_BUFFER_BIAS <= next_bias.rx;
      TX_BUFFER_BIAS <= next_bias.tx;
      LOOP_BANDWIDTH <= next_loop_bw;
    end
  end

  // calibration sequencer next values
  always_comb begin
    next_state = state;
    next_count = count;
    next_dac = DAC_INITIAL_STEP;
    next_result_a = RESULT_A;
    next_result_b = RESULT_B;
    case (state)
      CAL_IDLE: begin
        if (start_edge) begin
          next_state = CAL_RUN;
          next_count = start_periods;
          next_dac = {1'b0, wcal.step} + 4'h1;
        end
      end
      CAL_RUN: begin
        // an end in the abort cycle still stores
        if (cal_end) begin
          next_state = CAL_IDLE;
          if (cal.dual || !FREQ_SELECT) begin
            next_result_a = CAL_MEASURE;
          end
          if (cal.dual || FREQ_SELECT) begin
            next_result_b = CAL_MEASURE;
          end
          if (start_edge) begin
            next_state = CAL_RUN;
            next_count = start_periods;
            next_dac = {1'b0, wcal.step} + 4'h1;
          end
        end else if (abort) begin
          next_state = CAL_IDLE;
        end else if (REF_TICK) begin
          next_count = count - CNT_ONE;
        end
      end
      default: begin
        next_state = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= CAL_IDLE;
      count <= '0;
      CAL_ACTIVE <= 1'b0;
      DAC_INITIAL_STEP <= {1'b0, STEP_RST} + 4'h1;
      RESULT_A <= 8'h00;
      RESULT_B <= 8'h00;
    end else if (CE) begin
      state <= next_state;
      count <= next_count;
      CAL_ACTIVE <= (next_state == CAL_RUN);
      DAC_INITIAL_STEP <= next_dac;
      RESULT_A <= next_result_a;
      RESULT_B <= next_result_b;
    end
  end

  sequence seq_launch;
    CE && start_edge;
  endsequence

  sequence seq_finish;
    CE && cal_end && !start_edge;
  endsequence

  a_reset_bias_values: assert property (
    @(posedge CLK) SRST |=> (bias == BIAS_RST) && (PRE_BIAS_NUM == 4'h2)
      && (PRE_BIAS_DEN == 4'h3) && (LOOP_BANDWIDTH == LOOP_BANDWIDTH_RST))
    else $error("bias or bandwidth not at reset value");

  a_prescaler_two_fifths: assert property (
    @(posedge CLK) disable iff (SRST)
    (CE && wr_bias && WDATA[7:6] == 2'h3) |=>
      (PRE_BIAS_NUM == 4'h2) && (PRE_BIAS_DEN == 4'h5))
    else $error("prescaler code 3 not decoded as 2/5");

  a_buffer_bias_write: assert property (
    @(posedge CLK) disable iff (SRST)
    (CE && wr_bias) |=> (RX_BUFFER_BIAS == $past(WDATA[5:3]))
      && (TX_BUFFER_BIAS == $past(WDATA[2:0])))
    else $error("buffer bias fields not taken from write");

  a_bandwidth_readback: assert property (
    @(posedge CLK) disable iff (SRST)
    (CE && RD && ADDR == LOOP_BANDWIDTH_ADDR) |=> (RDATA == LOOP_BANDWIDTH))
    else $error("scaling factor read back wrong");

  a_launch_loads_wait: assert property (
    @(posedge CLK) disable iff (SRST)
    seq_launch |=> CAL_ACTIVE && (count == $past(start_periods)))
    else $error("calibration did not start with selected wait");

  a_dac_start_value: assert property (
    @(posedge CLK) disable iff (SRST)
    seq_launch |=> (DAC_INITIAL_STEP == {1'b0, $past(WDATA[2:0])} + 4'h1))
    else $error("dac start value is not iterate plus one");

  a_finish_to_idle: assert property (
    @(posedge CLK) disable iff (SRST)
    seq_finish |=> !CAL_ACTIVE && !cal.start && (state == CAL_IDLE))
    else $error("calibration did not end cleanly");

  a_dual_store_both: assert property (
    @(posedge CLK) disable iff (SRST)
    (seq_finish ##0 cal.dual) |=> (RESULT_A == $past(CAL_MEASURE))
      && (RESULT_B == $past(CAL_MEASURE)))
    else $error("dual calibration did not store both sets");

  a_single_store_one: assert property (
    @(posedge CLK) disable iff (SRST)
    (seq_finish ##0 (!cal.dual && !FREQ_SELECT)) |=>
      (RESULT_A == $past(CAL_MEASURE)) && $stable(RESULT_B))
    else $error("single calibration stored in wrong set");

  a_single_store_b: assert property (
    @(posedge CLK) disable iff (SRST)
    (seq_finish ##0 (!cal.dual && FREQ_SELECT)) |=>
      (RESULT_B == $past(CAL_MEASURE)) && $stable(RESULT_A))
    else $error("single calibration stored b in wrong set");

  a_no_start_without_edge: assert property (
    @(posedge CLK) disable iff (SRST)
    (CE && !CAL_ACTIVE && !start_edge) |=> !CAL_ACTIVE)
    else $error("calibration started without a rising start bit");

endmodule

`default_nettype wire

// *** tb/lo_bias_and_pll_calibration_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module lo_bias_and_pll_calibration_regs_tb;
  import lo_bias_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tick = 1'b0;
  logic fsel = 1'b0;
  logic [7:0] meas = 8'h00;
  logic [7:0] rdata, lbw, res_a, res_b;
  logic [3:0] num, den, dstep;
  logic [2:0] rxb, txb;
  logic act;
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] ea, eb, rv, cfg;

  // short wait counts 3..6 stand for the long ones
  lo_bias_and_pll_calibration_regs #(.WAIT0(3), .WAIT1(4), .WAIT2(5),
    .WAIT3(6)) uut (.CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .REF_TICK(tick),
    .FREQ_SELECT(fsel), .CAL_MEASURE(meas), .PRE_BIAS_NUM(num),
    .PRE_BIAS_DEN(den), .RX_BUFFER_BIAS(rxb), .TX_BUFFER_BIAS(txb),
    .LOOP_BANDWIDTH(lbw), .CAL_ACTIVE(act), .DAC_INITIAL_STEP(dstep),
    .RESULT_A(res_a), .RESULT_B(res_b));

  always #50 clk = ~clk;

  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
    input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
    @(posedge clk);
    #1;
    chk("rdata idle", 8'h00, rdata);
  endtask

  // prescaler fraction as numerator and denominator
  function automatic logic [7:0] pre_frac(input logic [1:0] c);
    case (c)
      2'h0: return 8'h11;
      2'h1: return 8'h23;
      2'h2: return 8'h12;
      default: return 8'h25;
    endcase
  endfunction

  // scaling factor for a reference of 7.126 MHz times 2**k
  function automatic logic [7:0] bw_factor(input int k);
    return 8'(174 + 16 * k);
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one full calibration with random tick spacing
  task automatic calib(input logic [7:0] c, input logic fs);
    int n;
    int t;
    int cnt;
    logic [7:0] m;
    n = int'(c[5:4]) + 3;
    m = 8'($urandom);
    @(posedge clk);
    fsel <= fs;
    meas <= m;
    wr_reg(CAL_CONTROL_ADDR, (c & 8'hF7) | 8'h80);
    chk("cal active", 8'h01, {7'h00, act});
    chk("dac step", {5'h00, c[2:0]} + 8'h01, {4'h0, dstep});
    cnt = 0;
    while (cnt < n) begin
      @(posedge clk);
      t = $urandom % 2;
      tick <= t[0];
      cnt += t;
      #1;
      chk("cal running", 8'h01, {7'h00, act});
    end
    @(posedge clk);
    tick <= 1'b0;
    #1;
    chk("cal done", 8'h00, {7'h00, act});
    if (c[6] || !fs) ea = m;
    if (c[6] || fs) eb = m;
    chk("result a", ea, res_a);
    chk("result b", eb, res_b);
    rd_chk("cal reg", CAL_CONTROL_ADDR, c & 8'h77);
  endtask

  initial begin
    rv = 8'($urandom(32'h049BBCC4));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("prescaler", 8'h23, {num, den});
    chk("rx bias", 8'h04, {5'h00, rxb});
    chk("tx bias", 8'h05, {5'h00, txb});
    chk("bandwidth", 8'h86, lbw);
    chk("dac step", 8'h06, {4'h0, dstep});
    rd_chk("bias reg", OSC_BUFFER_BIAS_ADDR, 8'h65);
    rd_chk("cal reg", CAL_CONTROL_ADDR, 8'h05);
    rd_chk("unmapped", 8'h3F, 8'h00);
    ea = 8'h00;
    eb = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rv = 8'($urandom);
      rv[7:6] = i[1:0];
      wr_reg(OSC_BUFFER_BIAS_ADDR, rv);
      chk("prescaler", pre_frac(rv[7:6]), {num, den});
      chk("rx bias", {5'h00, rv[5:3]}, {5'h00, rxb});
      chk("tx bias", {5'h00, rv[2:0]}, {5'h00, txb});
      rd_chk("bias reg", OSC_BUFFER_BIAS_ADDR, rv);
      rv = 8'($urandom);
      wr_reg(LOOP_BANDWIDTH_ADDR, rv);
      chk("bandwidth", rv, lbw);
      rd_chk("bw reg", LOOP_BANDWIDTH_ADDR, rv);
    end
    wr_reg(OSC_BUFFER_BIAS_ADDR, 8'h22);
    chk("tx bias low band", 8'h02, {5'h00, txb});
    wr_reg(OSC_BUFFER_BIAS_ADDR, 8'h25);
    chk("tx bias high band", 8'h05, {5'h00, txb});
    wr_reg(LOOP_BANDWIDTH_ADDR, bw_factor(1));
    chk("bandwidth", 8'hBE, lbw);
    // clock enable low ignores a write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(LOOP_BANDWIDTH_ADDR, 8'h5A);
    chk("bandwidth frozen", 8'hBE, lbw);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk("bw reg", LOOP_BANDWIDTH_ADDR, 8'hBE);
    for (int i = 0; i < 8; i++) begin
      cfg = 8'($urandom);
      cfg[5:4] = i[1:0];
      cfg[6] = i[2];
      calib(cfg, i[0]);
    end
    calib(8'h34, 1'b1);
    // abort in mid-run stores nothing
    wr_reg(CAL_CONTROL_ADDR, 8'hC7);
    rd_chk("busy", CAL_STATUS_ADDR, 8'h01);
    wr_reg(CAL_CONTROL_ADDR, 8'h47);
    chk("cal abort", 8'h00, {7'h00, act});
    rd_chk("idle", CAL_STATUS_ADDR, 8'h00);
    chk("result a", ea, res_a);
    wr_reg(RESULT_A_ADDR, 8'($urandom));
    rd_chk("result a reg", RESULT_A_ADDR, ea);
    rd_chk("result b reg", RESULT_B_ADDR, eb);
    // reset in mid-run stops calibration and clears results
    wr_reg(CAL_CONTROL_ADDR, 8'h87);
    chk("cal active", 8'h01, {7'h00, act});
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("cal reset", 8'h00, {7'h00, act});
    chk("result a reset", 8'h00, res_a);
    chk("result b reset", 8'h00, res_b);
    chk("dac reset", 8'h06, {4'h0, dstep});
    chk("bandwidth reset", 8'h86, lbw);
    rd_chk("cal reg", CAL_CONTROL_ADDR, 8'h05);
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
